// *** rtl/wsc_device.sv ***
// instrument end: status words, command decoder and value registers
`timescale 1ns/1ps
`default_nettype none
module wsc_device #(
  parameter int unsigned TICK_CYCLES = wsc_pkg::CLK_HZ  // cycles per clock second
) (
  input  wire logic               clk_sys_i,
  input  wire logic               reset_i,
  input  wire logic               clk_en_i,      // low freezes all state
  wsc_link_if.dev                 link,
  input  wire logic [3:0]         din_i,         // digital inputs active
  input  wire logic [3:0]         dout_i,        // digital outputs active
  input  wire logic [3:0]         sp_done_i,     // setpoint cycle done
  input  wire logic signed [31:0] weight_i,      // weight in thousandths
  input  wire logic signed [15:0] analog_mv_i,   // analog input in millivolts
  output logic                    running_o,     // left the wait state
  output logic                    remote_o,      // keys disabled
  output logic                    net_mode_o,    // net mode selected
  output logic                    flow_disp_o,   // flow rate on display
  output logic [3:0]              sp_active_o,   // setpoint enables
  output logic                    tare_o,        // auto tare pulse
  output logic                    zero_o,        // zero gross pulse
  output logic                    print_o,       // printout pulse
  output logic [31:0]             preset_tare_o  // preset tare value
);
  typedef struct packed {
    wsc_pkg::wsc_state_type st;
    logic                   remote;
    logic                   net;
    logic                   flow;
    logic [3:0]             sp_act;
    logic                   tare_p;
    logic                   zero_p;
    logic                   print_p;
    logic [15:0]            cerr;
    logic [31:0]            tare;
    logic [3:0][31:0]       lvl;
    logic [3:0][31:0]       spv;
    logic [31:0]            acc_hi;
    logic [31:0]            acc_lo;
    logic [31:0]            secs;
    logic [31:0]            tick;
    logic [3:0]             lvl_st;
    logic                   rsp_v;
    logic [7:0]             rsp_exc;
    logic [31:0]            rsp_d0;
    logic [31:0]            rsp_d1;
  } wsc_dev_type;

  wsc_dev_type q;  // registered state
  wsc_dev_type d;  // next state

  // unsigned bit word to single precision, exact for 16 bits
  function automatic logic [31:0] to_float(input logic [15:0] v);
    logic [4:0]  msb;
    logic [31:0] mant;
    msb = 5'h00;
    mant = 32'h0000_0000;
    for (int i = 0; i < wsc_pkg::HALF_W; i++)
    begin
      if (v[i])
      begin
        msb = 5'(i);
      end
    end
    if (v == 16'h0000)
    begin
      to_float = 32'h0000_0000;
    end
    else
    begin
      mant = {16'h0000, v} << (wsc_pkg::FLT_MANT_W - int'(msb));
      to_float = {1'b0, wsc_pkg::FLT_BIAS + {3'b000, msb}, mant[22:0]};
    end
  endfunction : to_float

  // bit registers share the optional float answer
  function automatic logic [31:0] bits_word(input logic [15:0] v, input logic flt);
    bits_word = flt ? to_float(v) : {16'h0000, v};
  endfunction : bits_word

  // next state: supervision, clock, then one link request per cycle
  always_comb
  begin
    logic [15:0]        code;
    logic [15:0]        spo;
    logic signed [31:0] sum;
    logic [7:0]         ofs;
    d = q;
    code = link.req_d0[15:0];
    spo = code - wsc_pkg::CMD_SP_FIRST;
    sum = $signed(q.acc_lo) + weight_i;
    ofs = link.req_addr - wsc_pkg::REG_LVL0;
    d.tare_p = 1'b0;
    d.zero_p = 1'b0;
    d.print_p = 1'b0;
    d.rsp_v = 1'b0;
    // weight strictly above each threshold
    for (int n = 0; n < wsc_pkg::NUM_CH; n++)
    begin
      d.lvl_st[n] = weight_i > $signed(q.lvl[n]);
    end
    // seconds counter behind the clock register
    if (q.tick >= TICK_CYCLES - 1)
    begin
      d.tick = 32'h0000_0000;
      d.secs = q.secs + 32'h0000_0001;
    end
    else
    begin
      d.tick = q.tick + 32'h0000_0001;
    end
    if (link.req_v)
    begin
      d.rsp_v = 1'b1;
      d.rsp_exc = wsc_pkg::EXC_NONE;
      d.rsp_d0 = 32'h0000_0000;
      d.rsp_d1 = 32'h0000_0000;
      if (!link.req_wr)
      begin
        // reads
        if (link.req_addr == wsc_pkg::REG_DIN)
          d.rsp_d0 = bits_word({12'h000, din_i}, link.req_flt);
        else if (link.req_addr == wsc_pkg::REG_DOUT)
          d.rsp_d0 = bits_word({12'h000, dout_i}, link.req_flt);
        else if (link.req_addr == wsc_pkg::REG_LVL_ST)
          d.rsp_d0 = bits_word({12'h000, q.lvl_st}, link.req_flt);
        else if (link.req_addr == wsc_pkg::REG_SP_ST)
          d.rsp_d0 = bits_word({8'h00, sp_done_i[3], q.sp_act[3], sp_done_i[2], q.sp_act[2],
                                sp_done_i[1], q.sp_act[1], sp_done_i[0], q.sp_act[0]},
                               link.req_flt);
        else if (link.req_addr == wsc_pkg::REG_ANALOG)
          d.rsp_d0 = {{16{analog_mv_i[15]}}, analog_mv_i};
        else if (link.req_addr == wsc_pkg::REG_CMD)
          d.rsp_d0 = 32'h0000_0000;
        else if (link.req_addr == wsc_pkg::REG_CMD_ERR)
          d.rsp_d0 = {16'h0000, q.cerr};
        else if (link.req_addr == wsc_pkg::REG_INST_ST)
          d.rsp_d0 = bits_word(16'(q.remote) << wsc_pkg::INST_REMOTE_BIT, link.req_flt);
        else if (link.req_addr == wsc_pkg::REG_STATE)
          d.rsp_d0 = {16'h0000, (q.st == wsc_pkg::WSC_RUN) ? wsc_pkg::STATE_RUN_CODE
                                                             : wsc_pkg::STATE_WAIT_CODE};
        else if (link.req_addr == wsc_pkg::REG_CLOCK)
          d.rsp_d0 = q.secs;
        else if (link.req_addr == wsc_pkg::REG_TARE)
          d.rsp_d0 = q.tare;
        else if (ofs < 8'h04)
          d.rsp_d0 = q.lvl[ofs[1:0]];
        else if (ofs < 8'h08)
          d.rsp_d0 = q.spv[ofs[1:0]];
        else if (link.req_addr == wsc_pkg::REG_ACC_HI)
        begin
          d.rsp_d0 = q.acc_hi;
          d.rsp_d1 = link.req_pair ? q.acc_lo : 32'h0000_0000;
        end
        else if (link.req_addr == wsc_pkg::REG_ACC_LO)
          d.rsp_d0 = q.acc_lo;
        else
          d.rsp_exc = wsc_pkg::EXC_ADDR;  // unmapped index
      end
      else if (link.req_addr == wsc_pkg::REG_CMD)
      begin
        // command decoder, exactly one action per accepted nonzero code
        d.cerr = wsc_pkg::CERR_NONE;
        if (code == wsc_pkg::CMD_NONE)
          d.cerr = wsc_pkg::CERR_NONE;
        else if (code == wsc_pkg::CMD_START)
        begin
          if (q.st == wsc_pkg::WSC_WAIT)
            d.st = wsc_pkg::WSC_RUN;
          else
          begin
            d.rsp_exc = wsc_pkg::EXC_VALUE;
            d.cerr = wsc_pkg::CERR_STATE;
          end
        end
        else if (code == wsc_pkg::CMD_REM_ON)
          d.remote = 1'b1;
        else if (code == wsc_pkg::CMD_REM_OFF)
          d.remote = 1'b0;
        else if (code == wsc_pkg::CMD_TARE)
          d.tare_p = 1'b1;
        else if (code == wsc_pkg::CMD_ZERO)
          d.zero_p = 1'b1;
        else if (code == wsc_pkg::CMD_GROSS)
          d.net = 1'b0;
        else if (code == wsc_pkg::CMD_NET)
          d.net = 1'b1;
        else if (code == wsc_pkg::CMD_DISP_WT)
          d.flow = 1'b0;
        else if (code == wsc_pkg::CMD_DISP_FL)
          d.flow = 1'b1;
        else if (code == wsc_pkg::CMD_PRINT)
        begin
          d.print_p = 1'b1;
          // low part wraps into high part at 10000 units
          if (sum >= wsc_pkg::ACC_WRAP)
          begin
            d.acc_lo = sum - wsc_pkg::ACC_WRAP;
            d.acc_hi = q.acc_hi + 32'h0000_0001;
          end
          else if (sum <= -wsc_pkg::ACC_WRAP)
          begin
            d.acc_lo = sum + wsc_pkg::ACC_WRAP;
            d.acc_hi = q.acc_hi - 32'h0000_0001;
          end
          else
            d.acc_lo = sum;
        end
        else if (code >= wsc_pkg::CMD_SP_FIRST && code <= wsc_pkg::CMD_SP_LAST)
          d.sp_act[spo[2:1]] = ~spo[0];
        else if (code == wsc_pkg::CMD_SP_ALL_ON)
          d.sp_act = 4'hF;
        else if (code == wsc_pkg::CMD_SP_ALL_OFF)
          d.sp_act = 4'h0;
        else
        begin
          d.rsp_exc = wsc_pkg::EXC_VALUE;
          d.cerr = wsc_pkg::CERR_CODE;
        end
      end
      else if (link.req_addr == wsc_pkg::REG_TARE)
        d.tare = link.req_d0;
      else if (ofs < 8'h04)
        d.lvl[ofs[1:0]] = link.req_d0;
      else if (ofs < 8'h08)
        d.spv[ofs[1:0]] = link.req_d0;
      else if (link.req_addr == wsc_pkg::REG_ACC_HI && link.req_pair)
      begin
        d.acc_hi = link.req_d0;
        d.acc_lo = link.req_d1;
      end
      else if (link.req_addr == wsc_pkg::REG_ACC_HI || link.req_addr == wsc_pkg::REG_ACC_LO)
      begin
        // a lone half would tear the total, so it is refused
        d.rsp_exc = wsc_pkg::EXC_VALUE;
        d.cerr = wsc_pkg::CERR_PAIR;
      end
      else
        d.rsp_exc = wsc_pkg::EXC_ADDR;  // read-only or unmapped
    end
  end

  // state register, frozen while the enable is low
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      q <= '0;
    else if (clk_en_i)
      q <= d;
  end

  assign link.rsp_v    = q.rsp_v;
  assign link.rsp_exc  = q.rsp_exc;
  assign link.rsp_d0   = q.rsp_d0;
  assign link.rsp_d1   = q.rsp_d1;
  assign running_o     = (q.st == wsc_pkg::WSC_RUN);
  assign remote_o      = q.remote;
  assign net_mode_o    = q.net;
  assign flow_disp_o   = q.flow;
  assign sp_active_o   = q.sp_act;
  assign tare_o        = q.tare_p;
  assign zero_o        = q.zero_p;
  assign print_o       = q.print_p;
  assign preset_tare_o = q.tare;
endmodule : wsc_device
`default_nettype wire

// *** rtl/wsc_link_if.sv ***
// register message link between remote master and instrument
`timescale 1ns/1ps
`default_nettype none
interface wsc_link_if;
  logic        req_v;    // one-cycle request pulse from master
  logic        req_wr;   // write when high, read when low
  logic        req_pair; // message carries two registers
  logic        req_flt;  // bit registers answered as float
  logic [7:0]  req_addr; // first register index
  logic [31:0] req_d0;   // first register value
  logic [31:0] req_d1;   // second register value
  logic        rsp_v;    // one-cycle answer pulse
  logic [7:0]  rsp_exc;  // exception code, zero for normal
  logic [31:0] rsp_d0;   // first read value
  logic [31:0] rsp_d1;   // second read value
  modport dev (input req_v, req_wr, req_pair, req_flt, req_addr, req_d0, req_d1,
               output rsp_v, rsp_exc, rsp_d0, rsp_d1);
  modport mst (output req_v, req_wr, req_pair, req_flt, req_addr, req_d0, req_d1,
               input rsp_v, rsp_exc, rsp_d0, rsp_d1);
endinterface : wsc_link_if
`default_nettype wire

// *** rtl/wsc_master.sv ***
// master end: turns software register orders into link messages
`timescale 1ns/1ps
`default_nettype none
module wsc_master (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic        clk_en_i,  // low freezes all state
  wsc_link_if.mst          link,
  input  wire logic [3:0]  addr_i,    // command port register index
  input  wire logic [31:0] wdata_i,   // write data
  input  wire logic        wr_i,      // write strobe
  input  wire logic        rd_i,      // read strobe
  output logic [31:0]      rdata_o    // read data, cycle after strobe
);
  typedef struct packed {
    wsc_pkg::wsc_hstate_type st;
    logic [7:0]              addr;
    logic [31:0]             d0;
    logic [31:0]             d1;
    logic                    wr;
    logic                    pair;
    logic                    flt;
    logic                    done;
    logic [7:0]              exc;
    logic [31:0]             r0;
    logic [31:0]             r1;
    logic [15:0]             cerr;
    logic [31:0]             rdata;
    logic                    req_v;
    logic                    req_wr;
    logic                    req_pair;
    logic                    req_flt;
    logic [7:0]              req_addr;
    logic [31:0]             req_d0;
    logic [31:0]             req_d1;
  } wsc_mst_type;

  wsc_mst_type q;  // registered state
  wsc_mst_type d;  // next state

  // next state: software port, then link sequencing
  always_comb
  begin
    logic busy;
    d = q;
    busy = (q.st != wsc_pkg::WSC_H_IDLE);
    d.req_v = 1'b0;
    // software reads, answered next cycle
    case (addr_i)
      wsc_pkg::H_ADDR:   d.rdata = {24'h000000, q.addr};
      wsc_pkg::H_DATA0:  d.rdata = q.d0;
      wsc_pkg::H_DATA1:  d.rdata = q.d1;
      wsc_pkg::H_STATUS: d.rdata = {16'h0000, q.exc, 6'h00, q.done, busy};
      wsc_pkg::H_RDATA0: d.rdata = q.r0;
      wsc_pkg::H_RDATA1: d.rdata = q.r1;
      wsc_pkg::H_CERR:   d.rdata = {16'h0000, q.cerr};
      default:           d.rdata = 32'h0000_0000;
    endcase
    if (!rd_i)
      d.rdata = 32'h0000_0000;
    // software writes; a go while busy is dropped
    if (wr_i)
    begin
      case (addr_i)
        wsc_pkg::H_ADDR:   d.addr = wdata_i[7:0];
        wsc_pkg::H_DATA0:  d.d0 = wdata_i;
        wsc_pkg::H_DATA1:  d.d1 = wdata_i;
        wsc_pkg::H_STATUS: d.done = 1'b0;
        wsc_pkg::H_CTRL:
        begin
          d.wr = wdata_i[wsc_pkg::CTRL_WR];
          d.flt = wdata_i[wsc_pkg::CTRL_FLT];
          // the accumulator pair always travels in one message
          d.pair = wdata_i[wsc_pkg::CTRL_PAIR] || (q.addr == wsc_pkg::REG_ACC_HI);
          if (wdata_i[wsc_pkg::CTRL_GO] && !busy)
          begin
            d.st = wsc_pkg::WSC_H_WAIT;
            d.req_v = 1'b1;
            d.req_wr = wdata_i[wsc_pkg::CTRL_WR];
            d.req_pair = d.pair;
            d.req_flt = wdata_i[wsc_pkg::CTRL_FLT];
            d.req_addr = q.addr;
            d.req_d0 = q.d0;
            d.req_d1 = q.d1;
          end
        end
        default: d.done = q.done;  // result indices are read-only, writes ignored
      endcase
    end
    // link sequencer
    case (q.st)
      wsc_pkg::WSC_H_IDLE: d.st = d.st;  // a go from software leaves idle
      wsc_pkg::WSC_H_WAIT:
      begin
        if (link.rsp_v)
        begin
          d.exc = link.rsp_exc;
          d.r0 = link.rsp_d0;
          d.r1 = link.rsp_d1;
          // illegal value: fetch the detail before reporting
          if (link.rsp_exc == wsc_pkg::EXC_VALUE)
            d.st = wsc_pkg::WSC_H_ERRQ;
          else
          begin
            d.st = wsc_pkg::WSC_H_IDLE;
            d.done = 1'b1;  // set wins over a clear in the same cycle
          end
        end
      end
      wsc_pkg::WSC_H_ERRQ:
      begin
        d.req_v = 1'b1;
        d.req_wr = 1'b0;
        d.req_pair = 1'b0;
        d.req_flt = 1'b0;
        d.req_addr = wsc_pkg::REG_CMD_ERR;
        d.st = wsc_pkg::WSC_H_ERRW;
      end
      wsc_pkg::WSC_H_ERRW:
      begin
        if (link.rsp_v)
        begin
          d.cerr = link.rsp_d0[15:0];
          d.st = wsc_pkg::WSC_H_IDLE;
          d.done = 1'b1;
        end
      end
      default:
      begin
        d.st = wsc_pkg::WSC_H_IDLE;
      end
    endcase
  end

  // state register, frozen while the enable is low
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      q <= '0;
    else if (clk_en_i)
      q <= d;
  end

  assign link.req_v    = q.req_v;
  assign link.req_wr   = q.req_wr;
  assign link.req_pair = q.req_pair;
  assign link.req_flt  = q.req_flt;
  assign link.req_addr = q.req_addr;
  assign link.req_d0   = q.req_d0;
  assign link.req_d1   = q.req_d1;
  assign rdata_o       = q.rdata;
endmodule : wsc_master
`default_nettype wire

// *** rtl/wsc_pkg.sv ***
// shared constants and types for the weigher status and command link
// How it works
// - input word bit n-1 mirrors input n
// - output word bit n-1 mirrors output n
// - level bit set while weight exceeds level
// - setpoint word: even bit active, odd done
// - analog register reports millivolts, about eleven volts
// - command register always reads as zero
// - accepted nonzero code triggers exactly one action
// - refused action answers exception, detail readable
// - start accepted only while waiting for start
// - code 2 remote on, 3 off
// - 10..13 tare, zero, gross, net
// - 14 weight, 15 flow display, 16 print
// - 100..107 per setpoint, 132/133 all
// - print adds weight into accumulated total
// - total equals high times 10000 units plus low thousandths
// - master clears total by writing zero pair
// - master write changes total only as paired message
// - clock registers give running time count
// - preset tare register reads and writes
// - four level registers hold supervision thresholds
// - four setpoint registers hold setpoint values
// - float read returns sum of set bits
// - exception 03 means illegal data value
package wsc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam int NUM_CH = 4;
  localparam int CLK_HZ = 50000000;  // system clock rate
  localparam int CLK_PERIOD_NS = 20;

  // device register indices
  localparam logic [7:0] REG_DIN     = 8'h00;
  localparam logic [7:0] REG_DOUT    = 8'h01;
  localparam logic [7:0] REG_LVL_ST  = 8'h02;
  localparam logic [7:0] REG_SP_ST   = 8'h03;
  localparam logic [7:0] REG_ANALOG  = 8'h04;
  localparam logic [7:0] REG_CMD     = 8'h05;
  localparam logic [7:0] REG_CMD_ERR = 8'h06;
  localparam logic [7:0] REG_INST_ST = 8'h07;
  localparam logic [7:0] REG_STATE   = 8'h08;
  localparam logic [7:0] REG_CLOCK   = 8'h09;
  localparam logic [7:0] REG_TARE    = 8'h0A;
  localparam logic [7:0] REG_LVL0    = 8'h10;
  localparam logic [7:0] REG_SPV0    = 8'h14;
  localparam logic [7:0] REG_ACC_HI  = 8'h18;
  localparam logic [7:0] REG_ACC_LO  = 8'h19;

  // command codes
  localparam logic [15:0] CMD_NONE     = 16'h0000;
  localparam logic [15:0] CMD_START    = 16'h0001;
  localparam logic [15:0] CMD_REM_ON   = 16'h0002;
  localparam logic [15:0] CMD_REM_OFF  = 16'h0003;
  localparam logic [15:0] CMD_TARE     = 16'h000A;
  localparam logic [15:0] CMD_ZERO     = 16'h000B;
  localparam logic [15:0] CMD_GROSS    = 16'h000C;
  localparam logic [15:0] CMD_NET      = 16'h000D;
  localparam logic [15:0] CMD_DISP_WT  = 16'h000E;
  localparam logic [15:0] CMD_DISP_FL  = 16'h000F;
  localparam logic [15:0] CMD_PRINT    = 16'h0010;
  localparam logic [15:0] CMD_SP_FIRST = 16'h0064;
  localparam logic [15:0] CMD_SP_LAST  = 16'h006B;
  localparam logic [15:0] CMD_SP_ALL_ON  = 16'h0084;
  localparam logic [15:0] CMD_SP_ALL_OFF = 16'h0085;

  // exception codes on the answer
  localparam logic [7:0] EXC_NONE  = 8'h00;
  localparam logic [7:0] EXC_ADDR  = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;

  // command error detail codes
  localparam logic [15:0] CERR_NONE  = 16'h0000;
  localparam logic [15:0] CERR_STATE = 16'h0001;
  localparam logic [15:0] CERR_CODE  = 16'h0002;
  localparam logic [15:0] CERR_PAIR  = 16'h0003;

  // instrument state codes and status bit
  localparam logic [15:0] STATE_WAIT_CODE = 16'h0001;
  localparam logic [15:0] STATE_RUN_CODE  = 16'h0003;
  localparam int INST_REMOTE_BIT = 0;

  // accumulated total: low part in thousandths, wraps at 10000 units
  localparam logic signed [31:0] ACC_SCALE = 32'sh0000_2710;
  localparam logic signed [31:0] ACC_WRAP  = 32'sh0098_9680;

  // single precision layout
  localparam logic [7:0] FLT_BIAS = 8'h7F;
  localparam int FLT_MANT_W = 23;

  // host side command port registers
  localparam logic [3:0] H_CTRL   = 4'h0;
  localparam logic [3:0] H_ADDR   = 4'h1;
  localparam logic [3:0] H_DATA0  = 4'h2;
  localparam logic [3:0] H_DATA1  = 4'h3;
  localparam logic [3:0] H_STATUS = 4'h4;
  localparam logic [3:0] H_RDATA0 = 4'h5;
  localparam logic [3:0] H_RDATA1 = 4'h6;
  localparam logic [3:0] H_CERR   = 4'h7;
  localparam int CTRL_GO   = 0;
  localparam int CTRL_WR   = 1;
  localparam int CTRL_PAIR = 2;
  localparam int CTRL_FLT  = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_EXC  = 8;

  typedef enum logic {WSC_WAIT, WSC_RUN} wsc_state_type;
  typedef enum logic [1:0] {WSC_H_IDLE, WSC_H_WAIT, WSC_H_ERRQ, WSC_H_ERRW} wsc_hstate_type;
endpackage : wsc_pkg

// *** tb/tb_weigher_status_command_regs.sv ***
// self-checking bench: master and device joined over the link
`timescale 1ns/1ps
`default_nettype none
module tb_weigher_status_command_regs;
  logic clk_sys_i = 0;
  logic reset_i = 1;
  logic wr = 0, rd = 0, run, rem, netm, flow, tare, zero, prt;
  logic [3:0] addr = 0, din = 0, dout = 0, spd = 0, spa, sa;
  logic [31:0] wdata = 0, rdata, ptare, r0, r1, x, s = 32'h0000_53E4;
  logic signed [31:0] wt = 0, lv [4];
  logic signed [15:0] amv = 0;
  logic [7:0] ex;
  int err_total = 0, checks_done = 0, cyc = 0, pulses = 0;
  wsc_link_if lnk ();
  wsc_master u_wsc_master (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .clk_en_i(1'b1),
    .link(lnk.mst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
  wsc_device #(.TICK_CYCLES(4)) u_wsc_device (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .clk_en_i(1'b1), .link(lnk.dev), .din_i(din), .dout_i(dout), .sp_done_i(spd),
    .weight_i(wt), .analog_mv_i(amv), .running_o(run), .remote_o(rem), .net_mode_o(netm),
    .flow_disp_o(flow), .sp_active_o(spa), .tare_o(tare), .zero_o(zero), .print_o(prt),
    .preset_tare_o(ptare));
  wsc_link_monitor u_wsc_link_monitor (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .req_v(lnk.req_v), .req_wr(lnk.req_wr), .req_flt(lnk.req_flt), .req_addr(lnk.req_addr),
    .req_d0(lnk.req_d0), .rsp_v(lnk.rsp_v), .rsp_exc(lnk.rsp_exc), .rsp_d0(lnk.rsp_d0));
  always #10 clk_sys_i = ~clk_sys_i;
  // cycle count for the hang limit, and a tally of action pulses
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    pulses <= pulses + tare + zero + prt;
    if (cyc == 30000)
    begin
      err_total++;
      stop_test();
    end
  end
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : rnd
  // float of a small bit word: leading one dropped into the hidden bit
  function automatic logic [31:0] fl(input logic [3:0] v);
    int m = 0;
    for (int i = 0; i < 4; i++) if (v[i]) m = i;
    return (v == 0) ? 32'h0 : {1'b0, 8'(127 + m), 23'(32'(v) << (23 - m))};
  endfunction : fl
  function automatic logic [31:0] spw(input logic [3:0] a, input logic [3:0] d);
    spw = 0;
    for (int i = 0; i < 4; i++) spw[2*i +: 2] = {d[i], a[i]};
  endfunction : spw
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one write strobe, then a free edge so strobes never collide
  task automatic hw(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
    @(posedge clk_sys_i);
  endtask : hw
  task automatic hr(input logic [3:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk_sys_i);
  endtask : hr
  // full link message through the master port; poll done, bounded
  task automatic msg(input logic w, input logic [7:0] a, input logic [31:0] d0, d1, f);
    logic [31:0] st = 0;
    hw(wsc_pkg::H_ADDR, {24'h0, a});
    hw(wsc_pkg::H_DATA0, d0);
    hw(wsc_pkg::H_DATA1, d1);
    hw(wsc_pkg::H_STATUS, 32'h0);
    hw(wsc_pkg::H_CTRL, {28'h0, f[0], 1'b0, w, 1'b1});
    for (int i = 0; i < 20 && !st[1]; i++) hr(wsc_pkg::H_STATUS, st);
    chk({31'h0, st[1]}, 32'h1);
    ex = st[15:8];
    hr(wsc_pkg::H_RDATA0, r0);
    hr(wsc_pkg::H_RDATA1, r1);
  endtask : msg
  task automatic cmd(input logic [15:0] c, input logic [7:0] e);
    msg(1'b1, wsc_pkg::REG_CMD, {16'h0, c}, 32'h0, 32'h0);
    chk({24'h0, ex}, {24'h0, e});
  endtask : cmd
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    for (int k = 0; k < 4; k++)
    begin
      x = rnd();
      din <= x[3:0];
      dout <= x[7:4];
      spd <= x[11:8];
      msg(0, wsc_pkg::REG_DIN, 0, 0, 0);
      chk(r0, {28'h0, din});
      msg(0, wsc_pkg::REG_DOUT, 0, 0, 0);
      chk(r0, {28'h0, dout});
      msg(0, wsc_pkg::REG_DIN, 0, 0, 1);
      chk(r0, fl(din));
    end
    $display("status words done");
    cmd(1, 0);
    chk(run, 1);
    cmd(1, 3);
    hr(wsc_pkg::H_CERR, r0);
    chk(r0, {16'h0, wsc_pkg::CERR_STATE});
    cmd(2, 0);
    chk(rem, 1);
    cmd(3, 0);
    chk(rem, 0);
    cmd(13, 0);
    chk(netm, 1);
    cmd(12, 0);
    chk(netm, 0);
    cmd(15, 0);
    chk(flow, 1);
    cmd(14, 0);
    chk(flow, 0);
    cmd(10, 0);
    cmd(11, 0);
    cmd(0, 0);
    chk(pulses, 2);
    cmd(5, 3);
    hr(wsc_pkg::H_CERR, r0);
    chk(r0, {16'h0, wsc_pkg::CERR_CODE});
    sa = 0;
    for (int c = 100; c < 108; c++)
    begin
      cmd(16'(c), 0);
      sa[(c - 100) / 2] = !c[0];
      chk(spa, sa);
      msg(0, wsc_pkg::REG_SP_ST, 0, 0, 0);
      chk(r0, spw(sa, spd));
    end
    cmd(132, 0);
    chk(spa, 4'hF);
    cmd(133, 0);
    chk(spa, 4'h0);
    msg(0, wsc_pkg::REG_CMD, 0, 0, 0);
    chk(r0, 0);
    $display("commands done");
    // weight equal to one level: equal must not count as above
    for (int i = 0; i < 4; i++)
    begin
      x = rnd();
      lv[i] = {{12{x[19]}}, x[19:0]};
      msg(1, wsc_pkg::REG_LVL0 + 8'(i), lv[i], 0, 0);
    end
    wt <= lv[1];
    msg(0, wsc_pkg::REG_LVL0 + 8'h2, 0, 0, 0);
    chk(r0, lv[2]);
    msg(0, wsc_pkg::REG_LVL_ST, 0, 0, 0);
    for (int i = 0; i < 4; i++) chk(r0[i], lv[1] > lv[i]);
    x = rnd();
    amv <= x[15:0];
    msg(1, wsc_pkg::REG_TARE, x, 0, 0);
    chk(ptare, x);
    msg(0, wsc_pkg::REG_TARE, 0, 0, 0);
    chk(r0, x);
    msg(1, wsc_pkg::REG_SPV0 + 8'h3, ~x, 0, 0);
    msg(0, wsc_pkg::REG_SPV0 + 8'h3, 0, 0, 0);
    chk(r0, ~x);
    msg(0, wsc_pkg::REG_ANALOG, 0, 0, 0);
    chk(r0, {{16{x[15]}}, x[15:0]});
    msg(0, wsc_pkg::REG_CLOCK, 0, 0, 0);
    x = r0;
    repeat (40) @(posedge clk_sys_i);
    msg(0, wsc_pkg::REG_CLOCK, 0, 0, 0);
    chk(r0 > x, 1);
    $display("value registers done");
    // low part crosses 10000 units on print, carry into high
    msg(1, wsc_pkg::REG_ACC_HI, 5, 9999000, 0);
    wt <= 2000;
    cmd(16, 0);
    msg(0, wsc_pkg::REG_ACC_HI, 0, 0, 0);
    chk(r0, 6);
    chk(r1, 1000);
    chk(pulses, 3);
    msg(1, wsc_pkg::REG_ACC_LO, 7, 0, 0);
    chk({24'h0, ex}, 32'h3);
    msg(0, wsc_pkg::REG_ACC_HI, 0, 0, 0);
    chk(r1, 1000);
    msg(1, wsc_pkg::REG_ACC_HI, 0, 0, 0);
    msg(0, wsc_pkg::REG_ACC_HI, 0, 0, 0);
    chk(r0 | r1, 0);
    $display("totals done");
    stop_test();
  end
endmodule : tb_weigher_status_command_regs
`default_nettype wire

// *** tb/wsc_link_monitor.sv ***
// link checker watching the message link between both ends
`timescale 1ns/1ps
`default_nettype none
module wsc_link_monitor (
  input wire logic        clk_sys_i,
  input wire logic        reset_i,
  input wire logic        req_v,
  input wire logic        req_wr,
  input wire logic        req_flt,
  input wire logic [7:0]  req_addr,
  input wire logic [31:0] req_d0,
  input wire logic        rsp_v,
  input wire logic [7:0]  rsp_exc,
  input wire logic [31:0] rsp_d0
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // command writes and plain reads, decoded once
  wire cw = req_v && req_wr && req_addr == wsc_pkg::REG_CMD;
  wire rw = req_v && !req_wr && !req_flt;
  AST_ANSWER: assert property (req_v |=> rsp_v) else $error("no answer");
  AST_NO_SPURIOUS: assert property (rsp_v |-> $past(req_v)) else $error("stray answer");
  AST_CMD_READS_ZERO: assert property (rw && req_addr == wsc_pkg::REG_CMD
    |=> rsp_d0 == 32'h0 && rsp_exc == wsc_pkg::EXC_NONE) else $error("command read");
  AST_CODE_ZERO: assert property (cw && req_d0 == 32'h0
    |=> rsp_exc == wsc_pkg::EXC_NONE) else $error("code zero refused");
  AST_UNKNOWN_CODE: assert property (cw && req_d0 inside {[4:9]}
    |=> rsp_exc == wsc_pkg::EXC_VALUE) else $error("unknown code taken");
  AST_SP_CODE: assert property (cw && req_d0 inside {[100:107]}
    |=> rsp_exc == wsc_pkg::EXC_NONE) else $error("setpoint code refused");
  AST_LONE_LOW: assert property (req_v && req_wr && req_addr == wsc_pkg::REG_ACC_LO
    |=> rsp_exc == wsc_pkg::EXC_VALUE) else $error("lone half taken");
  AST_DIN_WIDTH: assert property (rw && req_addr == wsc_pkg::REG_DIN
    |=> rsp_d0[31:4] == 28'h0) else $error("input word width");
  AST_SP_WIDTH: assert property (rw && req_addr == wsc_pkg::REG_SP_ST
    |=> rsp_d0[31:8] == 24'h0) else $error("setpoint word width");
endmodule : wsc_link_monitor
`default_nettype wire
